// file: verilog/usb_evt_pkg.sv
// constants for the usb event and interrupt block
package usb_evt_pkg;
   // register byte addresses
   localparam logic [31:0] ADDR_RETURN_LEN = 32'hfff06004;
   localparam logic [31:0] ADDR_IRQ_EN = 32'hfff06008;
   localparam logic [31:0] ADDR_IRQ_FLAGS = 32'hfff6000c;
   localparam logic [31:0] ADDR_IRQ_CLEAR = 32'hfff60010;
   // widths
   localparam int EVT_N = 16;
   localparam int LEN_W = 5;
   // values after reset
   localparam logic [4:0] RETURN_LEN_RST = 5'h00;
   localparam logic [15:0] IRQ_EN_RST = 16'h0000;
   localparam logic [15:0] FLAGS_RST = 16'h0000;
   // event bit positions
   localparam int BIT_CLOCKSTOP_WAKE = 15;
   localparam int BIT_BUS_RESET_DONE = 14;
   localparam int BIT_CONFIG_CHANGE = 13;
   localparam int BIT_BUS_TRANSITION = 12;
   localparam int BIT_CMD_STATUS_PHASE = 11;
   localparam int BIT_CMD_DATA_IN = 10;
   localparam int BIT_CMD_DATA_OUT = 9;
   localparam int BIT_VENDOR_REQUEST = 8;
   localparam int BIT_CLASS_REQUEST = 7;
   localparam int BIT_STRING_DESC = 6;
   localparam int BIT_CONFIG_DESC = 5;
   localparam int BIT_DEVICE_DESC = 4;
   localparam int BIT_ERROR = 3;
   localparam int BIT_WAKE = 2;
   localparam int BIT_SLEEP = 1;
   localparam int BIT_BUS_RESET = 0;
   // ahb encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;
endpackage

// file: verilog/event_flag_bank.sv
// sticky event flags with write-one-to-clear
`timescale 1ns/100ps
module event_flag_bank #(
   parameter int N = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [N-1:0] set_i,
   input wire logic [N-1:0] clr_i,
   output logic [N-1:0] flags_q
);
   // one sticky flag per event
   genvar k;
   generate
      for (k = 0; k < N; k++) begin : g_flag
         always_ff @(posedge clk) begin
            if (rst) begin
               flags_q[k] <= 1'h0;
            end else begin
               flags_q[k] <= set_i[k] | (flags_q[k] & ~clr_i[k]);
            end
         end
      end
   endgenerate

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // an event always lands, even under a clear
   property p_set_lands;
      (|set_i) |=> ((flags_q & $past(set_i)) == $past(set_i));
   endproperty
   a_set_lands: assert property (p_set_lands) else $error("event lost");

   // a clear without an event drops the flag
   property p_clear_drops;
      (|(clr_i & ~set_i)) |=> ((flags_q & $past(clr_i & ~set_i)) == '0);
   endproperty
   a_clear_drops: assert property (p_clear_drops) else $error("flag not cleared");
endmodule

// file: verilog/usb_event_irq.sv
// usb device event flags, enables, interrupt and return length on ahb
`timescale 1ns/100ps
module usb_event_irq (
   input wire logic clk,
   input wire logic rst,
   // ahb-lite slave port
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // one-cycle event strobes from the usb engine
   input wire logic clockstop_wake_evt,
   input wire logic bus_reset_done_evt,
   input wire logic config_change_evt,
   input wire logic bus_transition_evt,
   input wire logic cmd_status_phase_evt,
   input wire logic cmd_data_in_evt,
   input wire logic cmd_data_out_evt,
   input wire logic vendor_cmd_rx,
   input wire logic class_cmd_rx,
   input wire logic string_desc_evt,
   input wire logic config_desc_evt,
   input wire logic device_desc_evt,
   input wire logic error_evt,
   input wire logic wake_evt,
   input wire logic sleep_evt,
   input wire logic bus_reset_evt,
   // decode enables from the control register
   input wire logic class_decode_en,
   input wire logic vendor_decode_en,
   // outputs to cpu and usb engine
   output logic irq,
   output logic cmd_stall,
   output logic [4:0] return_byte_count
);
   // captured address phase
   logic wr_q;
   logic [31:0] addr_q;
   logic word_q;
   // registers
   logic [4:0] len_q;
   logic [15:0] en_q;
   logic [15:0] flags_q;
   logic irq_q;
   logic stall_q;
   logic [31:0] rdata_q;
   logic ready_q;
   logic resp_q;

   // accepted transfer in address phase
   wire logic acc = hsel & hready & htrans[1];
   wire logic rd_acc = acc & ~hwrite;

   // data-phase write strobes per register
   wire logic wr_go = wr_q & word_q;
   wire logic wr_len = wr_go & (addr_q == usb_evt_pkg::ADDR_RETURN_LEN);
   wire logic wr_en = wr_go & (addr_q == usb_evt_pkg::ADDR_IRQ_EN);
   wire logic wr_clr = wr_go & (addr_q == usb_evt_pkg::ADDR_IRQ_CLEAR);

   wire logic class_ok = class_cmd_rx & class_decode_en;
   wire logic vendor_ok = vendor_cmd_rx & vendor_decode_en;
   wire logic stall_d = (class_cmd_rx & ~class_decode_en) | (vendor_cmd_rx & ~vendor_decode_en);

   // event vector in flag bit order
   logic [15:0] set_vec;
   always_comb begin
      set_vec = '0;
      set_vec[usb_evt_pkg::BIT_CLOCKSTOP_WAKE] = clockstop_wake_evt;
      set_vec[usb_evt_pkg::BIT_BUS_RESET_DONE] = bus_reset_done_evt;
      set_vec[usb_evt_pkg::BIT_CONFIG_CHANGE] = config_change_evt;
      set_vec[usb_evt_pkg::BIT_BUS_TRANSITION] = bus_transition_evt;
      set_vec[usb_evt_pkg::BIT_CMD_STATUS_PHASE] = cmd_status_phase_evt;
      set_vec[usb_evt_pkg::BIT_CMD_DATA_IN] = cmd_data_in_evt;
      set_vec[usb_evt_pkg::BIT_CMD_DATA_OUT] = cmd_data_out_evt;
      set_vec[usb_evt_pkg::BIT_VENDOR_REQUEST] = vendor_ok;
      set_vec[usb_evt_pkg::BIT_CLASS_REQUEST] = class_ok;
      set_vec[usb_evt_pkg::BIT_STRING_DESC] = string_desc_evt;
      set_vec[usb_evt_pkg::BIT_CONFIG_DESC] = config_desc_evt;
      set_vec[usb_evt_pkg::BIT_DEVICE_DESC] = device_desc_evt;
      set_vec[usb_evt_pkg::BIT_ERROR] = error_evt;
      set_vec[usb_evt_pkg::BIT_WAKE] = wake_evt;
      set_vec[usb_evt_pkg::BIT_SLEEP] = sleep_evt;
      set_vec[usb_evt_pkg::BIT_BUS_RESET] = bus_reset_evt;
   end

   // write-one clears, zero bits do nothing
   wire logic [15:0] clr_vec = wr_clr ? hwdata[15:0] : 16'h0000;

   // flags only change by events and clears
   event_flag_bank #(.N(usb_evt_pkg::EVT_N)) u_flags (
      .clk(clk),
      .rst(rst),
      .set_i(set_vec),
      .clr_i(clr_vec),
      .flags_q(flags_q)
   );

   // read data mux, reserved bits read zero
   logic [31:0] rdata_d;
   always_comb begin
      case (haddr)
         usb_evt_pkg::ADDR_RETURN_LEN: rdata_d = {27'h0, len_q};
         usb_evt_pkg::ADDR_IRQ_EN: rdata_d = {16'h0000, en_q};
         usb_evt_pkg::ADDR_IRQ_FLAGS: rdata_d = {16'h0000, flags_q};
         default: rdata_d = 32'h00000000;
      endcase
   end

   // address phase capture
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= 1'h0;
         addr_q <= 32'h00000000;
         word_q <= 1'h0;
      end else if (hready) begin
         wr_q <= acc & hwrite;
         addr_q <= haddr;
         word_q <= (hsize == usb_evt_pkg::HSIZE_WORD);
      end
   end

   // read data registered into the data phase
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 32'h00000000;
      end else if (rd_acc) begin
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         len_q <= usb_evt_pkg::RETURN_LEN_RST;
      end else if (wr_len) begin
         len_q <= hwdata[usb_evt_pkg::LEN_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         en_q <= usb_evt_pkg::IRQ_EN_RST;
      end else if (wr_en) begin
         en_q <= hwdata[15:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_q <= 1'h0;
         stall_q <= 1'h0;
         ready_q <= 1'h0;
         // response flop, always okay
         resp_q <= usb_evt_pkg::HRESP_OKAY;
      end else begin
         irq_q <= |(flags_q & en_q);
         stall_q <= stall_d;
         ready_q <= 1'h1;
         resp_q <= usb_evt_pkg::HRESP_OKAY;
      end
   end

   // port drive, all from flops
   assign hrdata = rdata_q;
   assign hreadyout = ready_q;
   assign hresp = resp_q;
   assign irq = irq_q;
   assign cmd_stall = stall_q;
   assign return_byte_count = len_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // reserved length bits read zero
   property p_len_read;
      (rd_acc && haddr == usb_evt_pkg::ADDR_RETURN_LEN) |=> (hrdata[31:5] == 27'h0 && hrdata[4:0] == $past(len_q));
   endproperty
   a_len_read: assert property (p_len_read) else $error("length read wrong");

   // enables are zero straight after reset
   property p_en_reset;
      $past(rst) |-> (en_q == 16'h0000 && !irq);
   endproperty
   a_en_reset: assert property (p_en_reset) else $error("enable not cleared by reset");

   // with no event and no clear, writes to status change nothing
   property p_flags_ro;
      (wr_go && addr_q == usb_evt_pkg::ADDR_IRQ_FLAGS && set_vec == 16'h0000 && !wr_clr) |=> $stable(flags_q);
   endproperty
   a_flags_ro: assert property (p_flags_ro) else $error("status register written");

   // clock-stop wake lands in bit 15
   property p_clockstop_bit;
      clockstop_wake_evt |=> flags_q[15];
   endproperty
   a_clockstop_bit: assert property (p_clockstop_bit) else $error("bit 15 not set");

   // reset end lands in bit 14
   property p_reset_done_bit;
      bus_reset_done_evt |=> flags_q[14];
   endproperty
   a_reset_done_bit: assert property (p_reset_done_bit) else $error("bit 14 not set");

   // accepted class command lands in bit 7
   property p_class_bit;
      (class_cmd_rx && class_decode_en) |=> flags_q[7];
   endproperty
   a_class_bit: assert property (p_class_bit) else $error("class flag not set");

   // refused vendor command stalls and leaves no event
   property p_vendor_stall;
      (vendor_cmd_rx && !vendor_decode_en && !class_cmd_rx && !flags_q[8]) |=> (cmd_stall && !flags_q[8]);
   endproperty
   a_vendor_stall: assert property (p_vendor_stall) else $error("no stall on refused command");

   // clearing bus reset flag with no new event
   property p_clear_reset;
      (wr_clr && hwdata[0] && !bus_reset_evt) |=> !flags_q[0];
   endproperty
   a_clear_reset: assert property (p_clear_reset) else $error("bit 0 not cleared");

   // interrupt follows enabled flags one cycle later
   property p_irq_follow;
      ##1 (irq == |($past(flags_q) & $past(en_q)));
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("irq mismatch");

   // error interrupt needs its enable
   property p_error_gate;
      (flags_q == 16'h0008 && !en_q[3]) |=> !irq;
   endproperty
   a_error_gate: assert property (p_error_gate) else $error("error irq without enable");
endmodule

// file: test/usb_engine_model.sv
// behavioural usb engine that raises one-cycle event strobes
`timescale 1ns/100ps
module usb_engine_model (
   input wire logic clk,
   output logic [15:0] evt
);
   // strobes stay low outside a pulse
   initial evt = 16'h0000;
   // launch a strobe set for exactly one clock edge
   task automatic pulse(input logic [15:0] v);
      evt = v;
      @(negedge clk);
      evt = 16'h0000;
   endtask
endmodule

// file: test/tb_top.sv
// self-checking bench for the usb event and interrupt block
`timescale 1ns/100ps
module tb_top;
   logic clk, rst, hsel, hwrite, hready, class_decode_en, vendor_decode_en;
   logic [31:0] haddr, hwdata, rdv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, irq, cmd_stall;
   logic [31:0] hrdata;
   logic [4:0] return_byte_count;
   logic [15:0] evt;
   int fails = 0, n_compared = 0, cycles = 0;
   usb_engine_model eng (.clk(clk), .evt(evt));
   usb_event_irq dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .clockstop_wake_evt(evt[15]), .bus_reset_done_evt(evt[14]), .config_change_evt(evt[13]),
      .bus_transition_evt(evt[12]), .cmd_status_phase_evt(evt[11]), .cmd_data_in_evt(evt[10]),
      .cmd_data_out_evt(evt[9]), .vendor_cmd_rx(evt[8]), .class_cmd_rx(evt[7]), .string_desc_evt(evt[6]),
      .config_desc_evt(evt[5]), .device_desc_evt(evt[4]), .error_evt(evt[3]), .wake_evt(evt[2]),
      .sleep_evt(evt[1]), .bus_reset_evt(evt[0]), .class_decode_en(class_decode_en),
      .vendor_decode_en(vendor_decode_en), .irq(irq), .cmd_stall(cmd_stall),
      .return_byte_count(return_byte_count));
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // compare one value and count it
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // counts, verdict and end of run
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ahb write: address phase, then data phase
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
      hsel = 1'b1; htrans = 2'h2; hwrite = 1'b1; haddr = a; hsize = sz;
      @(negedge clk);
      hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; hwdata = d;
      @(negedge clk);
   endtask
   // ahb read: data taken in the data phase
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      hsel = 1'b1; htrans = 2'h2; hwrite = 1'b0; haddr = a; hsize = usb_evt_pkg::HSIZE_WORD;
      @(negedge clk);
      hsel = 1'b0; htrans = 2'h0;
      d = hrdata;
      @(negedge clk);
   endtask
   // read a register and compare
   task automatic rc(input logic [31:0] a, input logic [31:0] exp);
      rd(a, rdv);
      chk(rdv, exp);
   endtask
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         give_verdict();
      end
   end
   // main sequence
   initial begin
      rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
      hwdata = 32'h0; hready = 1'b1; class_decode_en = 1'b1; vendor_decode_en = 1'b1;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      rc(usb_evt_pkg::ADDR_RETURN_LEN, 32'h0);
      rc(usb_evt_pkg::ADDR_IRQ_EN, 32'h0);
      rc(usb_evt_pkg::ADDR_IRQ_FLAGS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      chk({30'h0, hreadyout, hresp}, 32'h2);
      rc(usb_evt_pkg::ADDR_IRQ_CLEAR, 32'h0);
      $display("test reset values done");
      wr(usb_evt_pkg::ADDR_RETURN_LEN, 32'hffff_ffff, usb_evt_pkg::HSIZE_WORD);
      rc(usb_evt_pkg::ADDR_RETURN_LEN, 32'h1f);
      chk({27'h0, return_byte_count}, 32'h1f);
      wr(usb_evt_pkg::ADDR_RETURN_LEN, 32'h0000_0005, 3'h0);
      rc(usb_evt_pkg::ADDR_RETURN_LEN, 32'h1f);
      wr(usb_evt_pkg::ADDR_IRQ_EN, 32'hffff_ffff, usb_evt_pkg::HSIZE_WORD);
      rc(usb_evt_pkg::ADDR_IRQ_EN, 32'h0000_ffff);
      wr(usb_evt_pkg::ADDR_IRQ_EN, 32'h0, usb_evt_pkg::HSIZE_WORD);
      rc(32'hfff0_6000, 32'h0);
      $display("test register access done");
      // every event bit: flag, gating, read-only, clear
      for (int i = 0; i < 16; i++) begin
         eng.pulse(16'h1 << i);
         rc(usb_evt_pkg::ADDR_IRQ_FLAGS, 32'h1 << i);
         chk({31'h0, irq}, 32'h0);
         wr(usb_evt_pkg::ADDR_IRQ_FLAGS, 32'h0, usb_evt_pkg::HSIZE_WORD);
         wr(usb_evt_pkg::ADDR_IRQ_CLEAR, 32'hffff ^ (32'h1 << i), usb_evt_pkg::HSIZE_WORD);
         rc(usb_evt_pkg::ADDR_IRQ_FLAGS, 32'h1 << i);
         wr(usb_evt_pkg::ADDR_IRQ_EN, 32'h1 << i, usb_evt_pkg::HSIZE_WORD);
         @(negedge clk);
         chk({31'h0, irq}, 32'h1);
         wr(usb_evt_pkg::ADDR_IRQ_CLEAR, 32'h1 << i, usb_evt_pkg::HSIZE_WORD);
         @(negedge clk);
         chk({31'h0, irq}, 32'h0);
         rc(usb_evt_pkg::ADDR_IRQ_FLAGS, 32'h0);
      end
      $display("test event flags done");
      // decode off: stall pulse instead of a flag
      class_decode_en = 1'b0;
      vendor_decode_en = 1'b0;
      for (int i = 7; i < 9; i++) begin
         eng.pulse(16'h1 << i);
         chk({31'h0, cmd_stall}, 32'h1);
         @(negedge clk);
         chk({31'h0, cmd_stall}, 32'h0);
         rc(usb_evt_pkg::ADDR_IRQ_FLAGS, 32'h0);
      end
      $display("test decode disabled done");
      // event and clear in one cycle: the event wins
      eng.pulse(16'h0008);
      hsel = 1'b1;
      htrans = 2'h2;
      hwrite = 1'b1;
      haddr = usb_evt_pkg::ADDR_IRQ_CLEAR;
      hsize = usb_evt_pkg::HSIZE_WORD;
      @(negedge clk);
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0000_0008;
      eng.pulse(16'h0008);
      rc(usb_evt_pkg::ADDR_IRQ_FLAGS, 32'h8);
      wr(usb_evt_pkg::ADDR_IRQ_CLEAR, 32'h8, usb_evt_pkg::HSIZE_WORD);
      rc(usb_evt_pkg::ADDR_IRQ_FLAGS, 32'h0);
      $display("test set beats clear done");
      give_verdict();
   end
endmodule
